// [rtl/conv_ctrl.sv]
// Conversion control pins of a three-pair sampling converter
//
// Function
// - Busy mode: status high throughout conversion
// - Sequential: status low one cycle per pair
// - Interrupt mode: high at latch, low after read
// - Parallel interface enabled only while select low
// - Serial frame starts at select falling edge
// - Data outputs driven only while read low
// - Hardware mode: start rise converts that pair
// - Hardware mode: start dropped early: pair partial power-down
// - Software: B/C start only when sequential
// - Software: A starts all, or A if sequential
// - Standby low powers down whole device
// - Reset aborts conversions, loads default control
// - Interface select: low parallel, high serial
`timescale 1ns/10ps
module conv_ctrl
  import conv_ctrl_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin,
  // Control pins from the host
  input wire conv_ctrl_pkg::pins_in_s pins_in,
  // Pin-side outputs
  output conv_ctrl_pkg::pins_out_s pins_out,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  import conv_ctrl_pkg::*;

  typedef logic [$clog2(CONV_LEN+1)-1:0] cnt_t;

  // Pin synchronisers
  pins_in_s sync1, sync2, prev;
  logic rst1, rst2;
  always_ff @(posedge aclk) begin
    sync1 <= pins_in;
    sync2 <= sync1;
    prev <= sync2;
    rst1 <= reset_pin;
    rst2 <= rst1;
  end

  wire logic hard_rst = !aresetn || rst2;
  wire logic powered = sync2.full_powerdown_n;
  wire logic sw_mode = sync2.pin_or_register_config_select;
  wire logic serial = sync2.interface_type_select;

  logic [31:0] control_word, next_control_word;
  wire logic seq_on = control_word[SEQ_BIT];
  wire logic int_mode = control_word[STATUS_FN_BIT];

  // Conversion state per pair
  logic [NPAIR-1:0] busy, next_busy, pd, next_pd, fire;
  cnt_t cnt [NPAIR], next_cnt [NPAIR];
  logic [NPAIR-1:0] rise, done, drop;
  logic result_ready, next_result_ready;
  logic seq_pulse;

  always_comb begin
    rise = sync2.start & ~prev.start;
    fire = '0;
    if (!sw_mode) begin
      fire = rise;
    end else if (seq_on) begin
      fire = rise;
    end else if (rise[0]) begin
      fire = '1;
    end
    fire = fire & ~busy & {NPAIR{powered}};
  end

  genvar g;
  generate
    for (g = 0; g < NPAIR; g++) begin : g_pair
      always_comb begin
        next_busy[g] = busy[g];
        next_cnt[g] = cnt[g];
        next_pd[g] = pd[g];
        done[g] = 1'b0;
        drop[g] = 1'b0;
        if (fire[g]) begin
          next_busy[g] = 1'b1;
          next_cnt[g] = cnt_t'(CONV_LEN - 1);
          next_pd[g] = 1'b0;
        end else if (busy[g]) begin
          if (!sw_mode && !sync2.start[g]) begin
            drop[g] = 1'b1;
            next_busy[g] = 1'b0;
            next_pd[g] = 1'b1;
          end else if (cnt[g] == '0) begin
            done[g] = 1'b1;
            next_busy[g] = 1'b0;
          end else begin
            next_cnt[g] = cnt[g] - cnt_t'(1);
          end
        end
        if (!powered) begin
          next_busy[g] = 1'b0;
        end
      end
      always_ff @(posedge aclk) begin
        if (hard_rst) begin
          busy[g] <= 1'b0;
          cnt[g] <= '0;
          pd[g] <= 1'b0;
        end else begin
          busy[g] <= next_busy[g];
          cnt[g] <= next_cnt[g];
          pd[g] <= next_pd[g];
        end
      end
    end
  endgenerate

  // Bus side
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [NEV-1:0] ev_status, next_ev_status, ev_mask, next_ev_mask;
  logic [NEV-1:0] events;
  logic result_read;
  logic status_q, next_status_q;

  function automatic logic known(input logic [7:0] a);
    known = a == OFS_CONTROL || a == OFS_STATE || a == OFS_IRQ_STATUS ||
            a == OFS_IRQ_MASK || a == OFS_RESULT;
  endfunction : known

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) old[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  wire logic wr_go = aw_hold && w_hold && !bvalid;
  wire logic rd_go = s_arvalid && !rvalid;

  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid && !s_bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !s_rready;
    next_rresp = rresp;
    next_rdata = rdata;
    next_control_word = control_word;
    next_ev_mask = ev_mask;
    next_ev_status = ev_status;
    result_read = 1'b0;
    if (s_awvalid && !aw_hold) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_awaddr;
    end
    if (s_wvalid && !w_hold) begin
      next_w_hold = 1'b1;
      next_w_data = s_wdata;
      next_w_strb = s_wstrb;
    end
    if (wr_go) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      unique case (aw_addr)
        OFS_CONTROL: next_control_word = merge(control_word, w_data, w_strb);
        OFS_IRQ_MASK: next_ev_mask = w_data[NEV-1:0];
        OFS_IRQ_STATUS: next_ev_status = ev_status & ~w_data[NEV-1:0];
        default: ;
      endcase
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = known(s_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_araddr)
        OFS_CONTROL: next_rdata = control_word;
        OFS_STATE: next_rdata = {24'h00_0000, result_ready, pd, busy, powered};
        OFS_IRQ_STATUS: next_rdata = {29'h0, ev_status};
        OFS_IRQ_MASK: next_rdata = {29'h0, ev_mask};
        OFS_RESULT: begin
          next_rdata = 32'h0000_0000;
          result_read = 1'b1;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    // A parallel read strobe under select also counts as reading
    if (!serial && !sync2.select_or_frame_sync && prev.read_n &&
        !sync2.read_n) begin
      result_read = 1'b1;
    end
    events = {result_read, |drop, |done};
    next_ev_status = next_ev_status | events; // Set beats clear
  end

  // Result and status pin
  always_comb begin
    next_result_ready = result_ready && !result_read;
    // A fresh result beats a read in the same cycle
    if (|done && !(|(busy & ~done))) begin
      next_result_ready = 1'b1;
    end
    seq_pulse = seq_on && |done;
    if (int_mode) begin
      next_status_q = next_result_ready;
    end else begin
      next_status_q = |next_busy && !seq_pulse;
    end
  end

  logic frame_start, data_oe;
  always_ff @(posedge aclk) begin
    if (hard_rst) begin
      control_word <= CTRL_RESET;
      aw_hold <= 1'b0;
      aw_addr <= '0;
      w_hold <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= '0;
      ev_status <= '0;
      ev_mask <= '0;
      result_ready <= 1'b0;
      status_q <= 1'b0;
      frame_start <= 1'b0;
      data_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      control_word <= next_control_word;
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      ev_status <= next_ev_status;
      ev_mask <= next_ev_mask;
      result_ready <= next_result_ready;
      status_q <= next_status_q;
      frame_start <= serial && prev.select_or_frame_sync &&
                     !sync2.select_or_frame_sync && powered;
      data_oe <= !serial && !sync2.select_or_frame_sync &&
                 !sync2.read_n && powered;
      irq <= |(next_ev_status & next_ev_mask);
    end
  end

  assign s_awready = !aw_hold;
  assign s_wready = !w_hold;
  assign s_bvalid = bvalid;
  assign s_bresp = bresp;
  assign s_arready = !rvalid;
  assign s_rvalid = rvalid;
  assign s_rresp = rresp;
  assign s_rdata = rdata;
  assign pins_out = {status_q, data_oe, frame_start, powered, pd};

  // Checks
  a_busy_high: assert property (@(posedge aclk) disable iff (hard_rst)
    (!int_mode && !seq_on && |busy && $stable(control_word)) |-> status_q)
    else $error("status low during conversion");
  a_seq_pulse: assert property (@(posedge aclk) disable iff (hard_rst)
    (!int_mode && seq_on && |done && $stable(control_word)) |=> !status_q)
    else $error("no sequential low pulse");
  a_int_clear: assert property (@(posedge aclk) disable iff (hard_rst)
    (int_mode && result_read && !(|done)) |=> !status_q)
    else $error("interrupt not cleared on read");
  a_par_gate: assert property (@(posedge aclk) disable iff (hard_rst)
    $past(sync2.select_or_frame_sync) |-> !data_oe)
    else $error("data driven with select high");
  a_read_gate: assert property (@(posedge aclk) disable iff (hard_rst)
    $past(sync2.read_n) |-> !data_oe)
    else $error("data driven with read high");
  a_frame_edge: assert property (@(posedge aclk) disable iff (hard_rst)
    frame_start |-> $past(serial) && !$past(sync2.select_or_frame_sync))
    else $error("frame start without falling select");
  a_early_drop: assert property (@(posedge aclk) disable iff (hard_rst)
    |drop && powered |=> |pd)
    else $error("no partial power-down on early drop");
  a_standby_idle: assert property (@(posedge aclk) disable iff (hard_rst)
    !powered |=> busy == '0)
    else $error("converting in standby");
  a_hw_start: assert property (@(posedge aclk) disable iff (hard_rst)
    (!sw_mode && fire[0]) |=> busy[0] || pd[0])
    else $error("pair A did not start");
  a_no_restart: assert property (@(posedge aclk) disable iff (hard_rst)
    busy[0] && cnt[0] != '0 && sync2.start[0] |=> cnt[0] == $past(cnt[0]) - 1
      || !busy[0])
    else $error("restart while busy");
  a_sw_all: assert property (@(posedge aclk) disable iff (hard_rst)
    (sw_mode && !seq_on && fire[0]) |-> fire == '1 || busy != '0)
    else $error("software start did not start all");
  a_sw_bc: assert property (@(posedge aclk) disable iff (hard_rst)
    (sw_mode && !seq_on && !rise[0]) |-> fire == '0)
    else $error("B or C start outside sequential mode");
endmodule : conv_ctrl

// [rtl/conv_ctrl_pkg.sv]
// Package: constants and carriers for the converter control-pin block
package conv_ctrl_pkg;
  localparam int NPAIR = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_03FF;
  localparam int STATUS_FN_BIT = 21;
  localparam int SEQ_BIT = 23;
  // Byte offsets of the bus registers
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  // Event bit positions in status and mask
  localparam int EV_DONE = 0;
  localparam int EV_EARLY_DROP = 1;
  localparam int EV_READ = 2;
  localparam int NEV = 3;
  // Conversion length in conversion clock cycles
  localparam int CONV_CYCLES = 20;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic pin_or_register_config_select;
    logic interface_type_select;
    logic full_powerdown_n;
    logic select_or_frame_sync;
    logic read_n;
    logic [NPAIR-1:0] start;
  } pins_in_s;

  typedef struct packed {
    logic status_pin;
    logic data_oe;
    logic frame_start;
    logic powered;
    logic [NPAIR-1:0] partial_pd;
  } pins_out_s;
endpackage : conv_ctrl_pkg

// [verification/host_start_model.sv]
// Host model that drives the three pair start inputs
`timescale 1ns/10ps
module host_start_model #(
  parameter int HOLD = 14
) (
  // Clock
  input wire logic aclk,
  // Commands from the bench
  input wire logic [2:0] go,
  input wire logic early,
  // Start pins
  output logic [2:0] start
);
  int cnt [3];
  initial start = 3'h0;
  initial cnt = '{0, 0, 0};
  // Start held over whole conversion unless told to drop early
  always @(posedge aclk) begin
    for (int i = 0; i < 3; i++) begin
      if (go[i]) begin
        start[i] <= 1'b1;
        cnt[i] <= early ? 2 : HOLD;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
        if (cnt[i] == 1) start[i] <= 1'b0;
      end
    end
  end
endmodule : host_start_model

// [verification/conv_ctrl_tb.sv]
// Self-checking bench for the converter control-pin block
`timescale 1ns/10ps
module conv_ctrl_tb;
  import conv_ctrl_pkg::*;
  logic aclk, aresetn, rp, sw, ser, full_powerdown_n_n, sel, rd_n, early, irq;
  logic [2:0] go, start;
  pins_in_s pins_in;
  pins_out_s pins_out;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  int n_fail = 0;
  int checks_done = 0;
  assign pins_in = {sw, ser, full_powerdown_n_n, sel, rd_n, start};
  host_start_model u_host (.aclk(aclk), .go(go), .early(early),
    .start(start));
  conv_ctrl #(.CONV_LEN(10)) DUT (.aclk(aclk), .aresetn(aresetn),
    .reset_pin(rp), .pins_in(pins_in), .pins_out(pins_out), .irq(irq),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
    .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready));
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh) begin
        bready <= 0;
        return;
      end
    end
    chk("write answer", 1, 0);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ah, vh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ah = arvalid & arready;
      d = rdata;
      vh = rvalid;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 0;
      if (vh) begin
        rready <= 0;
        return;
      end
    end
    chk("read answer", 1, 0);
  endtask : rd
  // Bounded wait for one output to reach a level
  task automatic wt(input int w, input logic lvl);
    logic v;
    for (int i = 0; i < 40; i++) begin
      @(negedge aclk);
      v = w == 0 ? pins_out.status_pin : w == 1 ? irq :
        w == 2 ? pins_out.frame_start : w == 3 ? pins_out.partial_pd[1] :
        w == 4 ? pins_out.data_oe : pins_out.powered;
      if (v === lvl) begin
        @(posedge aclk);
        return;
      end
    end
    chk($sformatf("output %0d", w), lvl, ~lvl);
  endtask : wt
  task automatic kick(input logic [2:0] p, input logic e);
    @(posedge aclk);
    go <= p;
    early <= e;
    @(posedge aclk);
    go <= 3'h0;
  endtask : kick
  task automatic t_reset;
    rd(OFS_CONTROL);
    chk("control", CTRL_RESET, d);
    rd(8'h20);
    chk("unmapped", RESP_SLVERR, r);
    wr(8'h20, 32'h0000_0000);
    chk("unmapped write", RESP_SLVERR, r);
    chk("irq", 0, irq);
  endtask : t_reset
  task automatic t_busy;
    kick(3'h1, 0);
    wt(0, 1);
    rd(OFS_STATE);
    chk("busy", 3'h1, d[3:1]);
    wt(0, 0);
    rd(OFS_IRQ_STATUS);
    chk("done", 1, d[EV_DONE]);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    wt(1, 1);
    wr(OFS_IRQ_STATUS, 32'h0000_0001);
    wt(1, 0);
  endtask : t_busy
  task automatic t_sw;
    sw <= 1;
    kick(3'h1, 0);
    wt(0, 1);
    rd(OFS_STATE);
    chk("all pairs", 3'h7, d[3:1]);
    wt(0, 0);
    wr(OFS_CONTROL, CTRL_RESET | 32'h0080_0000);
    kick(3'h1, 0);
    wt(0, 1);
    rd(OFS_STATE);
    chk("pair a only", 3'h1, d[3:1]);
    wt(0, 0);
    kick(3'h2, 0);
    wt(0, 1);
    rd(OFS_STATE);
    chk("pair b", 3'h2, d[3:1]);
    wt(0, 0);
    rd(OFS_RESULT);
    wr(OFS_CONTROL, CTRL_RESET | 32'h0020_0000);
    wt(0, 0);
    kick(3'h1, 0);
    wt(0, 1);
    rd(OFS_RESULT);
    wt(0, 0);
  endtask : t_sw
  task automatic t_pins;
    rd_n <= 0;
    sel <= 0;
    wt(4, 1);
    sel <= 1;
    wt(4, 0);
    sel <= 0;
    wt(4, 1);
    rd_n <= 1;
    wt(4, 0);
    ser <= 1;
    sel <= 1;
    repeat (4) @(posedge aclk);
    sel <= 0;
    wt(2, 1);
    full_powerdown_n_n <= 0;
    wt(5, 0);
    full_powerdown_n_n <= 1;
    wt(5, 1);
  endtask : t_pins
  task automatic t_early;
    sw <= 0;
    kick(3'h2, 1);
    wt(3, 1);
    rd(OFS_IRQ_STATUS);
    chk("early drop", 1, d[EV_EARLY_DROP]);
    wr(OFS_CONTROL, CTRL_RESET | 32'h0080_0000);
    kick(3'h1, 0);
    wt(0, 1);
    rp <= 1;
    repeat (4) @(posedge aclk);
    rp <= 0;
    repeat (2) @(posedge aclk);
    rd(OFS_STATE);
    chk("aborted", 3'h0, d[3:1]);
    wt(0, 0);
    rd(OFS_CONTROL);
    chk("control after reset", CTRL_RESET, d);
  endtask : t_early
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    #320000;
    n_fail++;
    end_of_test;
  end
  initial begin
    {aresetn, rp, sw, ser, sel, rd_n, early, go} = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 0;
    {awaddr, araddr, wdata} = 0;
    {full_powerdown_n_n, sel, rd_n} = 3'h7;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_busy;
    t_sw;
    t_pins;
    t_early;
    end_of_test;
  end
endmodule : conv_ctrl_tb
